// ### rtl/sacc_pkg.sv
// Constants for the successive-approximation converter control block.
// Assumes an 8-bit special function register port on the core clock.
// Functional notes
// [RULE_01] Clock-select code picks divide by 32/16/8/4.
// [RULE_02] Software keeps converter clock below 1 MHz.
// [RULE_03] Software sets clock-select before starting conversion.
// [RULE_04] Start bit begins conversion, self-clears at end.
// [RULE_05] End sets done flag, interrupt when enabled.
// [RULE_06] Write EFh or start clears done flag.
// [RULE_07] Channel codes: pins 0-9, ground, bandgap.
// [RULE_08] Conversion lasts 50 converter clock cycles.
// [RULE_09] Result loads together with done flag.
// [RULE_10] High byte bits 11-4, shared nibble 3-0.
// [RULE_11] Software keeps converter and touch channels apart.
// [RULE_12] Bandgap code keeps reference powered.
// [RULE_13] Bits decided MSB first, two clocks each.
// [RULE_14] Channel captured at start, held until done.
package sacc_pkg;
  // ==========================================================
  // Register addresses.
  localparam logic [7:0] ADDR_CLOCK_OPTIONS = 8'h94;
  localparam logic [7:0] ADDR_INT_FLAGS = 8'h95;
  localparam logic [7:0] ADDR_SHARED_RESULT = 8'haa;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hab;
  localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'hae;
  localparam logic [7:0] ADDR_AUX_CONTROL = 8'hf8;
  // ==========================================================
  // Field positions and reset values.
  localparam int DIV_SEL_LSB = 2;
  localparam int DONE_FLAG_BIT = 4;
  localparam int START_BIT = 4;
  localparam int CHAN_LSB = 4;
  localparam logic [7:0] RST_CLOCK_OPTIONS = 8'h00;
  localparam logic [7:0] RST_CHANNEL_SELECT = 8'hff;
  localparam logic [7:0] RST_AUX_CONTROL = 8'h00;
  localparam logic [7:0] FLAG_CLEAR_VALUE = 8'hef;
  // ==========================================================
  // Channel codes.
  localparam logic [3:0] CHAN_LAST_PIN = 4'h9;
  localparam logic [3:0] CHAN_GROUND = 4'ha;
  localparam logic [3:0] CHAN_BANDGAP = 4'hb;
  // ==========================================================
  // Timing in converter clock ticks and divide ratios minus one.
  localparam int CONV_TICKS = 50;
  localparam int RESULT_BITS = 12;
  localparam logic [4:0] DIV32_M1 = 5'h1f;
  localparam logic [4:0] DIV16_M1 = 5'h0f;
  localparam logic [4:0] DIV8_M1 = 5'h07;
  localparam logic [4:0] DIV4_M1 = 5'h03;
  typedef enum logic [1:0] {SACC_IDLE, SACC_SAMPLE, SACC_CONVERT} sacc_state_e;
endpackage

// ### rtl/sacc_ctrl.sv
// Converter control: register port, clock divider, sequencer and result store.
// Assumes the analog multiplexer and comparator sit outside, on the core clock.
`timescale 1ns/10ps
module sacc_ctrl #(
  parameter int CONV_TICKS = sacc_pkg::CONV_TICKS,
  parameter int RESULT_BITS = sacc_pkg::RESULT_BITS
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [3:0] touch_data_hi,
  input wire logic adc_int_en,
  output logic adc_irq_req,
  input wire logic cmp_in,
  output logic [11:0] dac_code,
  output logic sample_hold,
  output logic [3:0] mux_sel,
  output logic ground_sel,
  output logic bandgap_en
);
  localparam int SAMPLE_TICKS = CONV_TICKS - 2 * RESULT_BITS;

  // ==========================================================
  // Elaboration check.
  if (RESULT_BITS != 12 || SAMPLE_TICKS < 1 || CONV_TICKS > 63) begin : g_bad
    $error("sacc_ctrl: unsupported conversion length or result width");
  end

  logic [7:0] opt_q, opt_d, channel_select_register_q, channel_select_register_d, aux_q, aux_d, rdata_q, rdata_d;
  logic flag_q, flag_d, irq_q, irq_d;
  logic [11:0] res_q, res_d, trial_q, trial_d, final_res;
  logic [3:0] mux_q, mux_d;
  logic [4:0] div_q, div_d, div_max;
  logic [5:0] tick_q, tick_d;
  logic [4:0] phase;
  logic [3:0] bitn;
  sacc_pkg::sacc_state_e st_q, st_d;
  logic tick, done, start_wr, flag_wr, busy;

  // ==========================================================
  // Divider ratio and events.
  always_comb begin
    unique case (opt_q[sacc_pkg::DIV_SEL_LSB +: 2]) // see [RULE_01]
      2'b00: div_max = sacc_pkg::DIV32_M1;
      2'b01: div_max = sacc_pkg::DIV16_M1;
      2'b10: div_max = sacc_pkg::DIV8_M1;
      2'b11: div_max = sacc_pkg::DIV4_M1;
    endcase
  end

  assign busy = (st_q != sacc_pkg::SACC_IDLE);
  assign tick = busy && (div_q == div_max);
  assign start_wr = sfr_wr && (sfr_addr == sacc_pkg::ADDR_AUX_CONTROL)
                    && sfr_wdata[sacc_pkg::START_BIT];
  // Any write that leaves the flag bit at zero clears it, EFh included.
  assign flag_wr = sfr_wr && (sfr_addr == sacc_pkg::ADDR_INT_FLAGS)
                   && !sfr_wdata[sacc_pkg::DONE_FLAG_BIT];
  assign done = tick && (tick_q == 6'(CONV_TICKS - 1)); // see [RULE_08]
  assign phase = 5'(tick_q - 6'(SAMPLE_TICKS));
  assign bitn = 4'(11 - 32'(phase[4:1]));
  // Final value includes the decision on bit zero taken on the last tick.
  always_comb begin
    final_res = trial_q;
    if (!cmp_in) begin
      final_res[0] = 1'b0;
    end
  end

  // ==========================================================
  // Next-state logic for registers and sequencer.
  always_comb begin
    opt_d = opt_q;
    channel_select_register_d = channel_select_register_q;
    aux_d = aux_q;
    flag_d = flag_q;
    res_d = res_q;
    trial_d = trial_q;
    mux_d = mux_q;
    div_d = div_q;
    tick_d = tick_q;
    st_d = st_q;
    rdata_d = 8'h00;
    if (sfr_wr) begin
      unique case (sfr_addr)
        sacc_pkg::ADDR_CLOCK_OPTIONS: opt_d = sfr_wdata; // see [RULE_03]
        sacc_pkg::ADDR_CHANNEL_SELECT: channel_select_register_d = sfr_wdata;
        // The start bit belongs to the sequencer while a conversion runs.
        sacc_pkg::ADDR_AUX_CONTROL: begin
          aux_d = sfr_wdata;
          aux_d[sacc_pkg::START_BIT] = aux_q[sacc_pkg::START_BIT]
                                       || sfr_wdata[sacc_pkg::START_BIT];
        end
        default: ;
      endcase
    end
    if (flag_wr || start_wr) begin
      flag_d = 1'b0; // see [RULE_06]
    end
    // Divider restarts with each conversion so the tick count is exact.
    div_d = (!busy || tick) ? 5'h00 : 5'(div_q + 5'h01);
    unique case (st_q)
      sacc_pkg::SACC_IDLE: begin
        if (start_wr) begin // see [RULE_04]
          st_d = sacc_pkg::SACC_SAMPLE;
          tick_d = 6'h00;
          mux_d = sfr_wr && sfr_addr == sacc_pkg::ADDR_CHANNEL_SELECT ? sfr_wdata[7:4]
                  : channel_select_register_q[sacc_pkg::CHAN_LSB +: 4]; // see [RULE_14]
          trial_d = 12'h000;
        end
      end
      sacc_pkg::SACC_SAMPLE: begin
        if (tick) begin
          tick_d = 6'(tick_q + 6'h01);
          if (tick_q == 6'(SAMPLE_TICKS - 1)) begin
            st_d = sacc_pkg::SACC_CONVERT;
            trial_d = 12'h800; // see [RULE_13]
          end
        end
      end
      sacc_pkg::SACC_CONVERT: begin
        if (tick) begin
          tick_d = 6'(tick_q + 6'h01);
          // Even ticks let the comparator settle, odd ticks decide a bit.
          if (phase[0]) begin
            if (!cmp_in) begin
              trial_d[bitn] = 1'b0; // see [RULE_13]
            end
            if (bitn != 4'h0) begin
              trial_d[bitn - 4'h1] = 1'b1;
            end
          end
          if (done) begin
            st_d = sacc_pkg::SACC_IDLE;
            res_d = final_res; // see [RULE_09]
            aux_d[sacc_pkg::START_BIT] = 1'b0; // see [RULE_04]
            flag_d = 1'b1; // see [RULE_05]
          end
        end
      end
      default: st_d = sacc_pkg::SACC_IDLE;
    endcase
    if (sfr_rd) begin
      unique case (sfr_addr)
        sacc_pkg::ADDR_CLOCK_OPTIONS: rdata_d = opt_q;
        sacc_pkg::ADDR_INT_FLAGS: rdata_d = {3'b000, flag_q, 4'h0};
        sacc_pkg::ADDR_SHARED_RESULT: rdata_d = {res_q[3:0], touch_data_hi}; // see [RULE_10]
        sacc_pkg::ADDR_RESULT_HIGH: rdata_d = res_q[11:4]; // see [RULE_10]
        sacc_pkg::ADDR_CHANNEL_SELECT: rdata_d = channel_select_register_q;
        sacc_pkg::ADDR_AUX_CONTROL: rdata_d = aux_q;
        default: rdata_d = 8'h00;
      endcase
    end
    irq_d = flag_d && adc_int_en; // see [RULE_05]
  end

  // ==========================================================
  // State registers.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      opt_q <= sacc_pkg::RST_CLOCK_OPTIONS;
      channel_select_register_q <= sacc_pkg::RST_CHANNEL_SELECT;
      aux_q <= sacc_pkg::RST_AUX_CONTROL;
      flag_q <= 1'b0;
      irq_q <= 1'b0;
      res_q <= 12'h000;
      trial_q <= 12'h000;
      mux_q <= 4'hf;
      div_q <= 5'h00;
      tick_q <= 6'h00;
      st_q <= sacc_pkg::SACC_IDLE;
      rdata_q <= 8'h00;
    end else begin
      opt_q <= opt_d;
      channel_select_register_q <= channel_select_register_d;
      aux_q <= aux_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
      res_q <= res_d;
      trial_q <= trial_d;
      mux_q <= mux_d;
      div_q <= div_d;
      tick_q <= tick_d;
      st_q <= st_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Outputs; codes 11xx select no input at all.
  assign sfr_rdata = rdata_q;
  assign adc_irq_req = irq_q;
  assign dac_code = trial_q;
  assign sample_hold = (st_q == sacc_pkg::SACC_SAMPLE);
  assign mux_sel = (mux_q <= sacc_pkg::CHAN_LAST_PIN) ? mux_q : 4'hf; // see [RULE_07]
  assign ground_sel = (mux_q == sacc_pkg::CHAN_GROUND); // see [RULE_07]
  // Reference follows the live field so software can drop it for low standby current.
  assign bandgap_en = (channel_select_register_q[sacc_pkg::CHAN_LSB +: 4]
                       == sacc_pkg::CHAN_BANDGAP); // see [RULE_12]

  // ==========================================================
  // Length helper.
  // Cycles spent busy since the start was taken; it restarts from zero whenever idle.
  // The check below reads it at the completing tick, so it sees one less than the length.
  logic [11:0] busy_len_q, busy_len_d;
  always_comb begin
    busy_len_d = busy ? 12'(busy_len_q + 12'h001) : 12'h000;
  end
  // Plain register for the helper count.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy_len_q <= 12'h000;
    end else begin
      busy_len_q <= busy_len_d;
    end
  end

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_start_clears_flag: assert property (start_wr && !done |=> !flag_q) // see [RULE_06]
    else $error("start did not clear done flag");
  a_done_sets_flag: assert property (done |=> flag_q && !aux_q[4] && !busy) // see [RULE_04]
    else $error("completion did not set flag or clear start");
  a_result_load: assert property (done |=> res_q == $past(final_res)) // see [RULE_09]
    else $error("result not loaded with flag");
  a_div_by_four: assert property (tick && opt_q[3:2] == 2'b11 && busy |=> // see [RULE_01]
    !tick ##1 !tick ##1 !tick)
    else $error("divide by four ticks too often");
  a_channel_held: assert property (busy && $past(busy) |-> $stable(mux_q)) // see [RULE_14]
    else $error("channel changed during conversion");
  a_conv_length: assert property (done |-> // see [RULE_08]
    busy_len_q == 12'(CONV_TICKS * (32 >> opt_q[sacc_pkg::DIV_SEL_LSB +: 2]) - 1))
    else $error("conversion length wrong");
  a_irq_follows: assert property (done && adc_int_en |=> adc_irq_req) // see [RULE_05]
    else $error("interrupt request missing");
  a_sar_msb_first: assert property ($rose(st_q == sacc_pkg::SACC_CONVERT) |-> // see [RULE_13]
    trial_q == 12'h800)
    else $error("conversion did not start at msb");
  c_conversion: cover property (done);
  c_flag_cleared: cover property (flag_q ##1 flag_wr ##1 !flag_q);
  c_restart: cover property (done ##[1:20] start_wr);
endmodule

// ### verification/sacc_analog_model.sv
// Behavioural model of the analog multiplexer and comparator beside the control block.
// Assumes the control block latches the channel and drives a registered trial code.
`timescale 1ns/10ps
module sacc_analog_model #(
  parameter logic [11:0] BANDGAP_LEVEL = 12'h9c4
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [11:0] dac_code,
  input wire logic sample_hold,
  input wire logic [3:0] mux_sel,
  input wire logic ground_sel,
  input wire logic bandgap_en,
  output logic cmp_in
);
  // ==========================================================
  // Input routing.
  logic [11:0] level;
  logic [11:0] held_q;
  // Pins get distinct levels; a dead input shows the inverse of the held value.
  always_comb begin
    if (mux_sel <= 4'h9) begin
      level = 12'h3c5 + 12'h111 * {8'h00, mux_sel};
    end else if (ground_sel) begin
      level = 12'h000;
    end else if (bandgap_en) begin
      level = BANDGAP_LEVEL;
    end else begin
      level = ~held_q;
    end
  end
  // ==========================================================
  // Sample and hold, then an ideal comparator.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      held_q <= 12'h000;
    end else if (sample_hold) begin
      held_q <= level;
    end
  end
  // The hold capacitor keeps the input still while bits are decided.
  assign cmp_in = (held_q >= dac_code);
endmodule

// ### verification/sar_adc_conversion_control_tb.sv
// Self-checking bench for the converter control block and its analog model.
// Assumes register access by one-cycle strobes with read data one cycle later.
`timescale 1ns/10ps
module sar_adc_conversion_control_tb;
  localparam logic [11:0] BG = 12'h9c4;
  logic core_clk = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, adc_int_en = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [3:0] touch_data_hi = 4'h6, mux_sel;
  logic cmp_in, adc_irq_req, sample_hold, ground_sel, bandgap_en;
  logic [11:0] dac_code, exp_val;
  int n_mismatch = 0, checked = 0, cyc = 0, t0, n, dv;
  logic [3:0] chs [4] = '{4'h0, 4'h9, 4'ha, 4'hb};
  sacc_ctrl uut (.core_clk(core_clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .touch_data_hi(touch_data_hi), .adc_int_en(adc_int_en), .adc_irq_req(adc_irq_req),
    .cmp_in(cmp_in), .dac_code(dac_code), .sample_hold(sample_hold), .mux_sel(mux_sel),
    .ground_sel(ground_sel), .bandgap_en(bandgap_en));
  sacc_analog_model #(.BANDGAP_LEVEL(BG)) partner (.core_clk(core_clk), .rstn(rstn),
    .dac_code(dac_code), .sample_hold(sample_hold), .mux_sel(mux_sel),
    .ground_sel(ground_sel), .bandgap_en(bandgap_en), .cmp_in(cmp_in));
  // ==========================================================
  // Clock, cycle count and shared tasks.
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // The strobe is dropped on the edge that takes the write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_wr <= 1'b1; sfr_addr <= a; sfr_wdata <= d;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge core_clk);
    sfr_rd <= 1'b1; sfr_addr <= a;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1 chk(nm, {4'h0, e}, {4'h0, sfr_rdata});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence: reset values, then one conversion per divider code.
  initial begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    rd(8'h94, 8'h00, "options reset");
    rd(8'hae, 8'hff, "channel_select_register reset");
    rd(8'hf8, 8'h00, "aux reset");
    rd(8'h80, 8'h00, "unmapped read");
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      dv = 4 << i;
      exp_val = chs[i] <= 4'h9 ? 12'h3c5 + 12'h111 * {8'h00, chs[i]}
                : chs[i] == 4'ha ? 12'h0 : BG;
      @(posedge core_clk);
      adc_int_en <= (i != 2);
      wr(8'h94, 8'(3 - i) << 2);
      wr(8'hae, {chs[i], 4'hf});
      #1 chk("bandgap", {11'h0, chs[i] == 4'hb}, {11'h0, bandgap_en});
      wr(8'hf8, 8'h10);
      #1 t0 = cyc;
      rd(8'h95, 8'h00, "flag after start");
      rd(8'hf8, 8'h10, "start busy");
      chk("sample hold", 12'h001, {11'h0, sample_hold});
      repeat (28 * dv) @(posedge core_clk);
      wr(8'hae, 8'h8f);
      wr(8'hf8, 8'h00);
      rd(8'hf8, 8'h10, "start hold");
      chk("mux", {8'h0, chs[i] <= 4'h9 ? chs[i] : 4'hf}, {8'h0, mux_sel});
      chk("ground", {11'h0, chs[i] == 4'ha}, {11'h0, ground_sel});
      do begin
        @(posedge core_clk);
        #1 n = cyc - t0;
        if (n > 2000) begin
          n_mismatch++;
          $display("[FAIL] conversion wait expected end seen timeout");
          conclude();
        end
      end while (adc_int_en ? adc_irq_req !== 1'b1 : n < 50 * dv - 2);
      // Without the request line, a read taken on the completing edge must still see no flag.
      if (!adc_int_en) begin
        rd(8'h95, 8'h00, "flag before end");
        n = cyc - t0;
      end
      chk("duration", 12'(50 * dv), 12'(n));
      chk("irq", {11'h0, adc_int_en}, {11'h0, adc_irq_req});
      chk("dac code", exp_val, dac_code);
      rd(8'hf8, 8'h00, "start cleared");
      rd(8'h95, 8'h10, "flag set");
      rd(8'hab, exp_val[11:4], "result high");
      rd(8'haa, {exp_val[3:0], touch_data_hi}, "result low");
      if (i[0]) begin
        wr(8'h95, 8'hef);
        rd(8'h95, 8'h00, "flag cleared");
        chk("irq cleared", 12'h0, {11'h0, adc_irq_req});
      end
      $display("test conversion %0d done", i);
    end
    conclude();
  end
endmodule
